/* tb/watchdog_clock_and_timer_mode_tb.sv */
/* Self-checking bench for wdtm_top in timer mode.
 * Assumes the peripheral tick is every second cycle; the CPU clock runs except while the switch to the oscillator is checked. */
`timescale 1ns/100ps
module watchdog_clock_and_timer_mode_tb
	import wdtm_pkg::*;
;
	logic        i_clk = 1'b0;
	logic        i_osc_tick = 1'b0;
	logic        i_pclk_tick = 1'b0;
	logic        pf = 1'b0;
	logic        i_rstn, i_cpu_clock_on, i_power_down;
	logic        i_watchdog_interrupt_enable, o_timeout_flag, o_irq, o_wakeup;
	logic        o_osc_enable, o_wd_source_select;
	wdtm_wr_t    i_wr;
	logic [7:0]  o_watchdog_control, o_reload_value_register;
	int          n_errors, total_checks, k;
	int          cyc = 0;
	int          lr = 0;
	int          per = 0;
	int          nr = 0;
	logic [20:0] rows [5] = '{{5'h10, 8'hE5, 8'hE5}, {5'h08, 8'h7E, 8'h7E},
		{5'h10, 8'hA1, 8'hA1}, {5'h08, 8'h00, 8'h00}, {5'h10, 8'h04, 8'h04}};
	wdtm_top dut (.i_clk, .i_rstn, .i_wr, .i_osc_tick, .i_pclk_tick, .i_cpu_clock_on,
		.i_power_down, .i_watchdog_interrupt_enable, .o_watchdog_control,
		.o_reload_value_register, .o_timeout_flag, .o_irq, .o_wakeup, .o_osc_enable,
		.o_wd_source_select);
////////////////////////////////////////////////////////////////////////////////
	always #50 i_clk = ~i_clk;
	// The oscillator period is kept off the clock grid so its phase drifts.
	always #1230 i_osc_tick = ~i_osc_tick;
	always @(posedge i_clk) begin
		i_pclk_tick <= ~i_pclk_tick;
		cyc <= cyc + 1;
		pf <= o_timeout_flag;
		if (o_timeout_flag && !pf) begin
			per <= cyc - lr;
			lr <= cyc;
			nr <= nr + 1;
		end
	end
////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic wr(input logic [4:0] s, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= {s, d};
		@(posedge i_clk);
		i_wr <= '0;
	endtask
	task automatic feed;
		wr(5'h04, WDTM_FEED1_VAL);
		wr(5'h02, WDTM_FEED2_VAL);
	endtask
	task automatic waitr;
		int q;
		q = nr;
		for (int i = 0; i < 3000 && nr == q; i++) @(posedge i_clk);
		chk("underflow", nr != q, 1'b1);
		if (nr == q) close_out;
	endtask
	task automatic until_src(input logic v);
		for (int i = 0; i < 300 && o_wd_source_select !== v; i++) @(posedge i_clk);
		chk("source", o_wd_source_select, v);
		if (o_wd_source_select !== v) close_out;
	endtask
////////////////////////////////////////////////////////////////////////////////
	initial begin
		{i_rstn, i_power_down} = 2'b00;
		{i_cpu_clock_on, i_watchdog_interrupt_enable} = 2'b11;
		i_wr = '0;
		{n_errors, total_checks} = '0;
		repeat (6) @(posedge i_clk);
		i_rstn <= 1'b1;
		#1;
		chk("reset control", o_watchdog_control & 8'hE7, 8'hE5);
		chk("reset reload", o_reload_value_register, 8'hFF);
		chk("reset source", o_wd_source_select, 1'b1);
		foreach (rows[i]) begin
			wr(rows[i][20:16], rows[i][15:8]);
			#1;
			if (rows[i][19]) chk("reload", o_reload_value_register, rows[i][7:0]);
			else chk("control", o_watchdog_control & 8'hE5, rows[i][7:0] & 8'hE5);
		end
		chk("source before feed", o_wd_source_select, 1'b1);
		feed;
		until_src(1'b0);
		feed;
		waitr;
		chk("irq", o_irq, 1'b1);
		i_watchdog_interrupt_enable <= 1'b0;
		@(posedge i_clk);
		#1;
		chk("irq masked", o_irq, 1'b0);
		wr(5'h10, 8'h04);
		i_watchdog_interrupt_enable <= 1'b1;
		#1;
		chk("flag clear", o_timeout_flag, 1'b0);
		waitr;
		chk("period 33", per == 66, 1'b1);
		wr(5'h10, 8'h04);
		repeat (20) @(posedge i_clk);
		wr(5'h04, WDTM_FEED1_VAL);
		wr(5'h01, 8'h00);
		wr(5'h02, WDTM_FEED2_VAL);
		wr(5'h08, 8'h01);
		waitr;
		chk("bad feed", per == 66, 1'b1);
		wr(5'h10, 8'h04);
		waitr;
		chk("period 65", per == 130, 1'b1);
		wr(5'h10, 8'h04);
		repeat (20) @(posedge i_clk);
		feed;
		waitr;
		chk("feed reload", per > 140, 1'b1);
		wr(5'h10, 8'h04);
		k = nr;
		i_power_down <= 1'b1;
		repeat (300) @(posedge i_clk);
		chk("pd stop", nr == k, 1'b1);
		chk("osc off", o_osc_enable, 1'b0);
		i_power_down <= 1'b0;
		i_cpu_clock_on <= 1'b0;
		wr(5'h10, 8'h05);
		feed;
		repeat (150) @(posedge i_clk);
		chk("osc waits for cpu clock", o_wd_source_select, 1'b0);
		i_cpu_clock_on <= 1'b1;
		until_src(1'b1);
		i_power_down <= 1'b1;
		for (int i = 0; i < 4000 && o_wakeup !== 1'b1; i++) begin
			@(posedge i_clk);
			#1;
		end
		chk("wake", o_wakeup, 1'b1);
		chk("osc on", o_osc_enable, 1'b1);
		close_out;
	end
endmodule

bind wdtm_top wdtm_asserts #(.PRE_W(PRE_W), .CNT_W(CNT_W)) u_chk (.i_clk, .i_rstn, .i_wr,
	.i_power_down, .i_watchdog_interrupt_enable, .o_watchdog_control,
	.o_reload_value_register, .o_timeout_flag, .o_irq, .o_wakeup, .o_osc_enable,
	.o_wd_source_select);

/* tb/wdtm_asserts.sv */
/* Port checker for wdtm_top.
 * Assumes a bind that hands on its ports and parameters. */
`timescale 1ns/100ps
module wdtm_asserts
	import wdtm_pkg::*;
#(
	parameter int PRE_W = 3,
	parameter int CNT_W = 8
) (
	input wire logic       i_clk,
	input wire logic       i_rstn,
	input wire wdtm_wr_t   i_wr,
	input wire logic       i_power_down,
	input wire logic       i_watchdog_interrupt_enable,
	input wire logic [7:0] o_watchdog_control,
	input wire logic [7:0] o_reload_value_register,
	input wire logic       o_timeout_flag,
	input wire logic       o_irq,
	input wire logic       o_wakeup,
	input wire logic       o_osc_enable,
	input wire logic       o_wd_source_select
);
////////////////////////////////////////////////////////////////////////////////
	// A feed is only a necessary cause here, since a feed may keep the source.
	logic pend_ff;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pend_ff <= 1'b0;
		end else if (i_wr.feed2_we && i_wr.wdata == WDTM_FEED2_VAL) begin
			pend_ff <= 1'b1;
		end else if ($changed(o_wd_source_select)) begin
			pend_ff <= 1'b0;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
////////////////////////////////////////////////////////////////////////////////
	AST_IRQ: assert property (
		o_irq == (o_timeout_flag && i_watchdog_interrupt_enable))
		else $error("irq wrong");
	AST_FLAG_CLR: assert property (
		$fell(o_timeout_flag) |-> $past(i_wr.ctrl_we) && !$past(i_wr.wdata[WDTM_TOF_POS]))
		else $error("flag fell without a zero write");
	AST_CTRL_WR: assert property (
		i_wr.ctrl_we |=> (o_watchdog_control & 8'hE5) == ($past(i_wr.wdata) & 8'hE5))
		else $error("control readback wrong");
	AST_RELOAD_WR: assert property (
		i_wr.reload_we |=> o_reload_value_register == $past(i_wr.wdata))
		else $error("reload readback wrong");
	AST_WAKE_CAUSE: assert property (
		o_wakeup |-> $past(i_power_down) && o_wd_source_select)
		else $error("wake-up without cause");
	AST_WAKE_PULSE: assert property (o_wakeup |=> !o_wakeup)
		else $error("wake-up too long");
	AST_OSC_ON: assert property (i_power_down && o_wd_source_select |-> o_osc_enable)
		else $error("oscillator off");
	AST_SRC_FEED: assert property ($changed(o_wd_source_select) |-> pend_ff)
		else $error("source changed without feed");
	AST_PD_STOP: assert property (
		(i_power_down && !o_wd_source_select) [*8] |-> !$rose(o_timeout_flag))
		else $error("counted in power-down");
	cover property ($rose(o_timeout_flag));
	cover property (o_wakeup);
	cover property ($changed(o_wd_source_select));
endmodule

/* verilog/wdtm_pkg.sv */
/*
 * Constants, types and encodings for the watchdog timer in timer mode.
 * Assumes a single 10 MHz system clock and a CPU that presents register writes as
 * one-cycle strobes with byte data.
 */
// What this block does
// - The timeout is 2^(5+tap) times (reload+1) plus one watchdog clocks, 33 to 1,048,577.
// - The counter runs from the 400 KHz oscillator or the peripheral clock, chosen by bit 0.
// - A new clock selection takes effect only when a valid feed completes.
// - A switch drops the old source within two old ticks, then takes the new in two new ticks.
// - The prescaler restarts after a feed, so a switch may cost two old plus two new counts.
// - If the old clock stops mid-change counting stalls; the oscillator waits for the CPU clock.
// - In timer mode a control write reaches the shadow register after one watchdog clock.
// - In timer mode an underflow sets the timeout flag and, if enabled, requests an interrupt.
// - The timeout flag clears only when software writes a 0 to it.
// - On underflow the counter reloads from the reload register and keeps counting down.
// - Before an underflow the counter is loaded from the reload register only by a valid feed.
// - In timer mode an incorrect feed is ignored, with no reset and no reload.
// - In power-down the oscillator runs only if selected; otherwise counting stops.
// - Counting from the oscillator in power-down, each underflow wakes the device.
// - A feed is A5 to the first feed register then 5A to the second, no write between.
package wdtm_pkg;

	localparam logic [7:0] WDTM_FEED1_VAL  = 8'hA5;
	localparam logic [7:0] WDTM_FEED2_VAL  = 8'h5A;
	localparam int         WDTM_SEL_POS    = 0;
	localparam int         WDTM_TOF_POS    = 1;
	localparam int         WDTM_RUN_POS    = 2;
	localparam int         WDTM_PRE_LSB    = 5;
	localparam logic [7:0] WDTM_CTRL_RST   = 8'hE5;
	localparam logic [7:0] WDTM_RELOAD_RST = 8'hFF;
	localparam int         WDTM_PRE_BASE   = 5;
	localparam int         WDTM_SYNC_LEN   = 2;

	typedef struct packed {
		logic       ctrl_we;
		logic       reload_we;
		logic       feed1_we;
		logic       feed2_we;
		logic       other_we;
		logic [7:0] wdata;
	} wdtm_wr_t;

	typedef enum logic [2:0] {
		WDTM_FD_IDLE  = 3'b001,
		WDTM_FD_ARMED = 3'b010,
		WDTM_FD_DONE  = 3'b100
	} wdtm_feed_t;

endpackage

/* verilog/wdtm_top.sv */
/*
 * Watchdog timer in timer mode with switchable clock source and feed logic.
 * Assumes the oscillator tick arrives asynchronously on a pin, and that the
 * peripheral tick is a same-clock strobe from the clock generator.
 */
`timescale 1ns/100ps

module wdtm_top
	import wdtm_pkg::*;
#(
	parameter int PRE_W = 3,
	parameter int CNT_W = 8
) (
	input  wire logic     i_clk,
	input  wire logic     i_rstn,
	input  wire wdtm_wr_t i_wr,
	input  wire logic     i_osc_tick,
	input  wire logic     i_pclk_tick,
	input  wire logic     i_cpu_clock_on,
	input  wire logic     i_power_down,
	input  wire logic     i_watchdog_interrupt_enable,
	output logic [7:0]    o_watchdog_control,
	output logic [7:0]    o_reload_value_register,
	output logic          o_timeout_flag,
	output logic          o_irq,
	output logic          o_wakeup,
	output logic          o_osc_enable,
	output logic          o_wd_source_select
);

	////////////////////////////////////////////////////////////////////////////
	// Oscillator tick enters through three flops; a rising edge counts once the last two agree.

	// A level caught mid-change never makes a tick, since the last two flops must agree first.
	logic [2:0] osc_sync_ff;
	logic       osc_lvl_ff;
	logic       osc_agree;
	logic       osc_tick;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			osc_sync_ff <= 3'h0;
			osc_lvl_ff  <= 1'b0;
		end else begin
			osc_sync_ff <= {osc_sync_ff[1:0], i_osc_tick};
			if (osc_agree) begin
				osc_lvl_ff <= osc_sync_ff[2];
			end
		end
	end
	assign osc_agree = (osc_sync_ff[1] == osc_sync_ff[2]);
	assign osc_tick  = osc_agree && osc_sync_ff[2] && !osc_lvl_ff;

	////////////////////////////////////////////////////////////////////////////
	// Software-visible registers.

	logic [7:0] ctrl_ff;
	logic [7:0] reload_ff;
	logic       tof_ff;
	logic       uflow;
	logic       feed_ok;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl_ff <= WDTM_CTRL_RST;
		end else if (i_wr.ctrl_we) begin
			ctrl_ff <= i_wr.wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			reload_ff <= WDTM_RELOAD_RST;
		end else if (i_wr.reload_we) begin
			reload_ff <= i_wr.wdata;
		end
	end

	// The flag is set by underflow; a set in the same cycle as a 0 write wins.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tof_ff <= 1'b0;
		end else if (uflow) begin
			tof_ff <= 1'b1;
		end else if (i_wr.ctrl_we && !i_wr.wdata[WDTM_TOF_POS]) begin
			tof_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Feed sequence detector; a wrong or broken sequence just disarms.

	wdtm_feed_t fd_ff;
	logic       any_we;
	assign any_we = i_wr.ctrl_we | i_wr.reload_we | i_wr.feed1_we | i_wr.feed2_we
		| i_wr.other_we;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			fd_ff <= WDTM_FD_IDLE;
		end else begin
			case (fd_ff)
				WDTM_FD_IDLE, WDTM_FD_DONE: begin
					if (i_wr.feed1_we && i_wr.wdata == WDTM_FEED1_VAL) begin
						fd_ff <= WDTM_FD_ARMED;
					end else begin
						fd_ff <= WDTM_FD_IDLE;
					end
				end
				WDTM_FD_ARMED: begin
					if (i_wr.feed2_we && i_wr.wdata == WDTM_FEED2_VAL) begin
						fd_ff <= WDTM_FD_DONE;
					end else if (i_wr.feed1_we && i_wr.wdata == WDTM_FEED1_VAL) begin
						fd_ff <= WDTM_FD_ARMED;
					end else if (any_we) begin
						fd_ff <= WDTM_FD_IDLE;
					end
				end
				default: fd_ff <= WDTM_FD_IDLE;
			endcase
		end
	end
	assign feed_ok = (fd_ff == WDTM_FD_DONE);

	////////////////////////////////////////////////////////////////////////////
	// Clock source selection and glitch-free changeover.

	logic       sel_req_ff;
	logic       sel_ff;
	logic       switching_ff;
	logic [1:0] sw_cnt_ff;
	logic       old_gone_ff;
	logic       old_tick;
	logic       new_tick;
	logic       wd_tick;
	logic       pclk_tick;

	// Selection request is latched only by a completed feed.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sel_req_ff <= WDTM_CTRL_RST[WDTM_SEL_POS];
		end else if (feed_ok) begin
			sel_req_ff <= ctrl_ff[WDTM_SEL_POS];
		end
	end

	// Power-down stops the peripheral clock, so its ticks vanish for the changeover too.
	assign pclk_tick = i_pclk_tick && !i_power_down;
	assign old_tick  = sel_ff ? osc_tick : pclk_tick;
	assign new_tick  = sel_ff ? pclk_tick : osc_tick;

	// Two ticks of the old source to drop it, two of the new to take it. If the old
	// source stops, counting stalls here rather than risk a runt tick.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sel_ff       <= WDTM_CTRL_RST[WDTM_SEL_POS];
			switching_ff <= 1'b0;
			sw_cnt_ff    <= 2'h0;
			old_gone_ff  <= 1'b0;
		end else if (!switching_ff) begin
			if (sel_req_ff != sel_ff) begin
				switching_ff <= 1'b1;
				sw_cnt_ff    <= 2'h0;
				old_gone_ff  <= 1'b0;
			end
		end else if (!old_gone_ff) begin
			if (old_tick) begin
				sw_cnt_ff <= sw_cnt_ff + 2'h1;
				if (sw_cnt_ff == 2'(WDTM_SYNC_LEN - 1)) begin
					old_gone_ff <= 1'b1;
					sw_cnt_ff   <= 2'h0;
				end
			end
		end else if (new_tick && (sel_ff || i_cpu_clock_on)) begin
			sw_cnt_ff <= sw_cnt_ff + 2'h1;
			if (sw_cnt_ff == 2'(WDTM_SYNC_LEN - 1)) begin
				sel_ff       <= ~sel_ff;
				switching_ff <= 1'b0;
			end
		end
	end

	// Peripheral ticks stop in power-down, which halts counting on that source.
	assign wd_tick = !switching_ff && ctrl_ff[WDTM_RUN_POS] &&
		(sel_ff ? osc_tick : pclk_tick);

	////////////////////////////////////////////////////////////////////////////
	// Shadow control, prescaler and down counter.

	logic [7:0]       shadow_ff;
	logic [PRE_W-1:0] tap;
	logic [19:0]      pre_ff;
	logic [19:0]      pre_lim;
	logic [CNT_W-1:0] cnt_ff;
	logic             uflow_ff;

	// Timer mode: the shadow follows the control register on each watchdog clock.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			shadow_ff <= WDTM_CTRL_RST;
		end else if (wd_tick) begin
			shadow_ff <= ctrl_ff;
		end
	end

	assign tap     = shadow_ff[WDTM_PRE_LSB +: PRE_W];
	assign pre_lim = 20'(20'h1 << (WDTM_PRE_BASE + int'(tap))) - 20'h1;

	// Counting (reload+1) prescaler periods, plus one final tick, gives the timeout.
	// The limit is a compare, not an equality, so a tap lowered mid-period cannot
	// strand the prescaler above its new limit for a whole wrap.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pre_ff   <= 20'h0;
			cnt_ff   <= CNT_W'(WDTM_RELOAD_RST);
			uflow_ff <= 1'b0;
		end else if (feed_ok) begin
			pre_ff   <= 20'h0;
			cnt_ff   <= CNT_W'(reload_ff);
			uflow_ff <= 1'b0;
		end else if (wd_tick) begin
			if (uflow_ff) begin
				uflow_ff <= 1'b0;
				cnt_ff   <= CNT_W'(reload_ff);
				pre_ff   <= 20'h0;
			end else if (pre_ff >= pre_lim) begin
				pre_ff <= 20'h0;
				if (cnt_ff == '0) begin
					uflow_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff - CNT_W'(1);
				end
			end else begin
				pre_ff <= pre_ff + 20'h1;
			end
		end
	end
	assign uflow = wd_tick && uflow_ff && !feed_ok;

	////////////////////////////////////////////////////////////////////////////
	// Outputs.

	logic wake_ff;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wake_ff <= 1'b0;
		end else begin
			wake_ff <= uflow && i_power_down && sel_ff;
		end
	end

	assign o_watchdog_control      = {ctrl_ff[7:2], tof_ff, ctrl_ff[0]};
	assign o_reload_value_register = reload_ff;
	assign o_timeout_flag          = tof_ff;
	assign o_irq                   = tof_ff & i_watchdog_interrupt_enable;
	assign o_wakeup                = wake_ff;
	assign o_osc_enable            = !i_power_down || sel_ff || sel_req_ff;
	assign o_wd_source_select      = sel_ff;

endmodule
